// ### shared/brw_pkg.sv
package brw_pkg;

  // register space of the device
  localparam logic [28:0] BRW_REG_BASE       = 29'h0320_0000;
  localparam logic [15:0] BRW_ROM_CTRL_OFS   = 16'h0080;
  localparam logic [15:0] BRW_CLK_CTRL_OFS   = 16'h0084;

  // boot location and rom bank 0 window
  localparam logic [28:0] BRW_BOOT_ADDR      = 29'h0000_0000;
  localparam logic [28:0] BRW_ROM0_LAST      = 29'h00FF_FFFF;

  // rom_bank0_control fields
  localparam logic [7:0]  BRW_ROM_CTRL_RESET = 8'h40;
  localparam int          BRW_NSEQ_LSB       = 0;
  localparam int          BRW_NSEQ_W         = 3;
  localparam int          BRW_BURST_LSB      = 3;
  localparam int          BRW_HALF_SPEED_BIT = 5;
  localparam int          BRW_WIDTH16_BIT    = 6;

  // non-sequential access length: slowest length, last code and fastest length
  localparam logic [4:0]  BRW_NSEQ_SLOWEST   = 5'h07;
  localparam logic [2:0]  BRW_NSEQ_LAST_CODE = 3'h5;
  localparam logic [4:0]  BRW_NSEQ_FASTEST   = 5'h02;

  // clock_divider_control fields: a set bit selects divide by 1
  localparam logic [7:0]  BRW_CLK_CTRL_RESET = 8'h00;
  localparam int          BRW_CPU_DIV1_BIT   = 0;
  localparam int          BRW_MEM_DIV1_BIT   = 1;
  localparam int          BRW_IO_DIV1_BIT    = 2;

  // rom location step in bytes
  localparam logic [28:0] BRW_LOC_STEP       = 29'h0000_0004;

  typedef struct packed {
    logic [28:0] addr;
  } brw_fetch_req_t;

  typedef struct packed {
    logic [28:0] addr;
    logic        cs_n;
    logic        oe_n;
  } brw_rom_pins_t;

endpackage

// ### design/brw_boot_rom_fetch.sv
// Functional notes
// - after reset the width-select bit of rom_bank0_control is one, so fetches start as from a 16-bit rom.
// - after reset instruction fetching starts at physical address zero in rom bank 0.
// - in 16-bit mode each word is the low halves of two consecutive locations, first one low, next one high.
// - in 16-bit mode the upper 16 data bits of each rom location are thrown away.
// - a width change only affects fetches issued after the write; a fetch already issued keeps its width.
// - rom_bank0_control takes a byte write at offset 0x80 of the register base; zero means 32-bit, slowest, no burst.
// - after reset the cpu, memory and io clocks are divided by 2, and software may set each to divide by 1.
// - the non-sequential length from the low three bits doubles in 16-bit mode and doubles again at half speed.
`timescale 1ns/1ps
`default_nettype none
module brw_boot_rom_fetch (
  input  wire logic                    sys_clk,
  input  wire logic                    resetn,
  input  wire logic                    reg_sel,
  input  wire logic [15:0]             reg_addr,
  input  wire logic                    reg_wr,
  input  wire logic [7:0]              reg_wdata,
  output logic [7:0]                   reg_rdata,
  input  wire logic                    fetch_valid,
  input  wire brw_pkg::brw_fetch_req_t fetch_req,
  output logic                         fetch_ready,
  output logic                         fetch_ack,
  output logic [31:0]                  fetch_data,
  output logic [28:0]                  boot_addr,
  output brw_pkg::brw_rom_pins_t       rom_pins,
  input  wire logic [31:0]             rom_data,
  output logic                         cpu_clk_en,
  output logic                         mem_clk_en,
  output logic                         io_clk_en,
  output logic                         width16_active
);
  import brw_pkg::*;

  // rom data reaches the capture point two flip-flops late
  localparam logic [1:0] SYNC_AGE = 2'h2;

  typedef enum logic [1:0] {
    BRW_IDLE,
    BRW_FIRST,
    BRW_SECOND
  } brw_state_t;

  brw_state_t  state_reg, state_next;
  logic [7:0]  rom_ctrl_reg;
  logic [7:0]  clk_ctrl_reg;
  logic [2:0]  div_reg;
  logic [31:0] rom_s1_reg, rom_s2_reg;
  logic [28:0] loc_addr_reg;
  logic        wide16_reg;
  logic        half_reg;
  logic [2:0]  nseq_reg;
  logic [4:0]  cnt_reg;
  logic [15:0] low_half_reg;
  logic        ack_reg;
  logic [31:0] data_reg;
  logic        cs_reg;
  logic [1:0]  age_reg;

  // register decode
  wire         wr_rom_ctrl = reg_sel && reg_wr && (reg_addr == BRW_ROM_CTRL_OFS);
  wire         wr_clk_ctrl = reg_sel && reg_wr && (reg_addr == BRW_CLK_CTRL_OFS);
  wire         rd_rom_ctrl = reg_sel && (reg_addr == BRW_ROM_CTRL_OFS);
  wire         rd_clk_ctrl = reg_sel && (reg_addr == BRW_CLK_CTRL_OFS);

  assign reg_rdata = rd_rom_ctrl ? rom_ctrl_reg :
                     rd_clk_ctrl ? clk_ctrl_reg : 8'h00;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rom_ctrl_reg <= BRW_ROM_CTRL_RESET;
      clk_ctrl_reg <= BRW_CLK_CTRL_RESET;
    end else begin
      if (wr_rom_ctrl) begin
        rom_ctrl_reg <= reg_wdata;
      end
      if (wr_clk_ctrl) begin
        clk_ctrl_reg <= reg_wdata;
      end
    end
  end

  // one divider per clock; a divide-by-2 output pulses every other cycle
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_div
      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          div_reg[g] <= 1'b0;
        end else begin
          div_reg[g] <= ~div_reg[g];
        end
      end
    end
  endgenerate

  assign cpu_clk_en = clk_ctrl_reg[BRW_CPU_DIV1_BIT] | div_reg[0];
  assign mem_clk_en = clk_ctrl_reg[BRW_MEM_DIV1_BIT] | div_reg[1];
  assign io_clk_en  = clk_ctrl_reg[BRW_IO_DIV1_BIT]  | div_reg[2];

  assign boot_addr = BRW_BOOT_ADDR;
  assign width16_active = rom_ctrl_reg[BRW_WIDTH16_BIT];

  // rom data comes from pins, so it is synchronised before use
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rom_s1_reg <= 32'h0000_0000;
      rom_s2_reg <= 32'h0000_0000;
    end else begin
      rom_s1_reg <= rom_data;
      rom_s2_reg <= rom_s1_reg;
    end
  end

  // access length of one rom location, in memory clock ticks
  wire [4:0] nseq_base = (nseq_reg <= BRW_NSEQ_LAST_CODE) ?
                         (BRW_NSEQ_SLOWEST - {2'b00, nseq_reg}) : BRW_NSEQ_FASTEST;
  // per location doubled at half speed; two locations per word give the 16-bit doubling
  wire [4:0] loc_len   = half_reg ? {nseq_base[3:0], 1'b0} : nseq_base;
  // a location never ends before its own data has crossed the synchroniser,
  // so the fastest code without half speed at an undivided memory clock costs one extra cycle
  wire       loc_done  = mem_clk_en && (cnt_reg >= (loc_len - 5'd1)) && (age_reg == SYNC_AGE);

  wire       accept    = (state_reg == BRW_IDLE) && fetch_valid;
  wire       in_rom0   = fetch_req.addr <= BRW_ROM0_LAST;
  // in 16-bit mode word n sits in locations 2n and 2n+1
  wire [28:0] first_loc = rom_ctrl_reg[BRW_WIDTH16_BIT] ?
                          {fetch_req.addr[27:0], 1'b0} : fetch_req.addr;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      BRW_IDLE: begin
        if (accept) begin
          state_next = BRW_FIRST;
        end
      end
      BRW_FIRST: begin
        if (loc_done) begin
          state_next = wide16_reg ? BRW_SECOND : BRW_IDLE;
        end
      end
      BRW_SECOND: begin
        if (loc_done) begin
          state_next = BRW_IDLE;
        end
      end
      default: begin
        state_next = BRW_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= BRW_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // width and timing are frozen per fetch when it is taken
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wide16_reg   <= BRW_ROM_CTRL_RESET[BRW_WIDTH16_BIT];
      half_reg     <= 1'b0;
      nseq_reg     <= 3'h0;
      loc_addr_reg <= BRW_BOOT_ADDR;
      cs_reg       <= 1'b0;
    end else if (accept) begin
      wide16_reg   <= rom_ctrl_reg[BRW_WIDTH16_BIT];
      half_reg     <= rom_ctrl_reg[BRW_HALF_SPEED_BIT];
      nseq_reg     <= rom_ctrl_reg[BRW_NSEQ_LSB +: BRW_NSEQ_W];
      loc_addr_reg <= first_loc;
      cs_reg       <= in_rom0;
    end else if (loc_done && (state_reg == BRW_FIRST)) begin
      loc_addr_reg <= loc_addr_reg + BRW_LOC_STEP;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= 5'd0;
    end else if (accept || loc_done) begin
      cnt_reg <= 5'd0;
    end else if (mem_clk_en && (state_reg != BRW_IDLE)) begin
      cnt_reg <= cnt_reg + 5'd1;
    end
  end

  // cycles spent on the current location, saturating
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      age_reg <= 2'h0;
    end else if (accept || loc_done) begin
      age_reg <= 2'h0;
    end else if (age_reg != SYNC_AGE) begin
      age_reg <= age_reg + 2'h1;
    end
  end

  // assembly of the answer word
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      low_half_reg <= 16'h0000;
      ack_reg      <= 1'b0;
      data_reg     <= 32'h0000_0000;
    end else begin
      ack_reg <= 1'b0;
      if (loc_done && (state_reg == BRW_FIRST)) begin
        if (wide16_reg) begin
          low_half_reg <= rom_s2_reg[15:0];
        end else begin
          data_reg <= rom_s2_reg;
          ack_reg  <= 1'b1;
        end
      end else if (loc_done && (state_reg == BRW_SECOND)) begin
        data_reg <= {rom_s2_reg[15:0], low_half_reg};
        ack_reg  <= 1'b1;
      end
    end
  end

  assign fetch_ready   = (state_reg == BRW_IDLE);
  assign fetch_ack     = ack_reg;
  assign fetch_data    = data_reg;
  assign rom_pins.addr = loc_addr_reg;
  assign rom_pins.cs_n = ~(cs_reg && (state_reg != BRW_IDLE));
  assign rom_pins.oe_n = (state_reg == BRW_IDLE);

endmodule
`default_nettype wire

// ### bench/brw_rom_model.sv
`timescale 1ns/1ps
`default_nettype none
module brw_rom_model import brw_pkg::*; (
  input  wire logic          sys_clk,
  input  wire brw_rom_pins_t rom_pins,
  output logic [31:0]        rom_data
);
  logic [31:0] last_reg;
  wire logic        sel  = !rom_pins.oe_n && !rom_pins.cs_n;
  wire logic [31:0] word = {~rom_pins.addr[15:0], rom_pins.addr[15:0] ^ 16'h5A3C};
  always @(posedge sys_clk)
    if (sel) last_reg <= word;
  // deselected bus shows the inverse of the last word so a stale sample cannot match
  assign rom_data = sel ? word : ~last_reg;
endmodule
`default_nettype wire

// ### bench/brw_checker.sv
`timescale 1ns/1ps
`default_nettype none
module brw_checker import brw_pkg::*; (
  input wire logic          sys_clk,
  input wire logic          resetn,
  input wire logic          reg_sel,
  input wire logic [15:0]   reg_addr,
  input wire logic          reg_wr,
  input wire logic [7:0]    reg_wdata,
  input wire logic [7:0]    reg_rdata,
  input wire logic          fetch_valid,
  input wire logic          fetch_ready,
  input wire logic          fetch_ack,
  input wire logic [28:0]   boot_addr,
  input wire brw_rom_pins_t rom_pins,
  input wire logic          mem_clk_en,
  input wire logic          width16_active
);
  logic [2:0] div1_reg;
  wire logic wr_rom = reg_sel && reg_wr && reg_addr == BRW_ROM_CTRL_OFS;
  wire logic w6     = reg_wdata[BRW_WIDTH16_BIT];
  always_ff @(posedge sys_clk or negedge resetn)
    if (!resetn) div1_reg <= 3'h0;
    else if (reg_sel && reg_wr && reg_addr == BRW_CLK_CTRL_OFS) div1_reg <= reg_wdata[2:0];
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  sequence take_s; fetch_valid && fetch_ready; endsequence
  sequence busy_ack_s; !fetch_ready [*2] ##[1:80] fetch_ack; endsequence
  width_reset_a: assert property (!$past(resetn) |-> width16_active) else $error("width not 16 after reset");
  boot_zero_a: assert property (boot_addr == BRW_BOOT_ADDR) else $error("boot address not zero");
  bank0_sel_a: assert property (!rom_pins.oe_n && rom_pins.addr <= BRW_ROM0_LAST |-> !rom_pins.cs_n)
    else $error("bank 0 not selected");
  width_write_a: assert property (wr_rom |=> width16_active == $past(w6)) else $error("width write lost");
  ctrl_read_a: assert property (reg_sel && reg_addr == BRW_ROM_CTRL_OFS |-> reg_rdata[BRW_WIDTH16_BIT] == width16_active)
    else $error("width bit read wrong");
  mem_div2_a: assert property (!div1_reg[1] && mem_clk_en |=> div1_reg[1] || !mem_clk_en)
    else $error("memory clock not halved");
  mem_gap_a: assert property ($fell(mem_clk_en) |=> mem_clk_en) else $error("memory enable gap too long");
  ack_pulse_a: assert property (fetch_ack |=> !fetch_ack) else $error("ack longer than one cycle");
  fetch_time_a: assert property (take_s |=> busy_ack_s) else $error("fetch not answered in time");
endmodule
bind brw_boot_rom_fetch brw_checker chk (.sys_clk(sys_clk), .resetn(resetn), .reg_sel(reg_sel),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .fetch_valid(fetch_valid), .fetch_ready(fetch_ready), .fetch_ack(fetch_ack), .boot_addr(boot_addr),
  .rom_pins(rom_pins), .mem_clk_en(mem_clk_en), .width16_active(width16_active));
`default_nettype wire

// ### bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import brw_pkg::*;
  logic sys_clk, resetn, reg_sel, reg_wr, fetch_valid, fetch_ready, fetch_ack;
  logic cpu_clk_en, mem_clk_en, io_clk_en, width16_active;
  logic [15:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, r;
  logic [31:0] fetch_data, rom_data, d;
  logic [28:0] boot_addr;
  brw_fetch_req_t fetch_req;
  brw_rom_pins_t rom_pins;
  int err_count, checked, lat, lat_n;
  brw_boot_rom_fetch uut (.sys_clk(sys_clk), .resetn(resetn), .reg_sel(reg_sel), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .fetch_valid(fetch_valid),
    .fetch_req(fetch_req), .fetch_ready(fetch_ready), .fetch_ack(fetch_ack), .fetch_data(fetch_data),
    .boot_addr(boot_addr), .rom_pins(rom_pins), .rom_data(rom_data), .cpu_clk_en(cpu_clk_en),
    .mem_clk_en(mem_clk_en), .io_clk_en(io_clk_en), .width16_active(width16_active));
  brw_rom_model rom_model (.sys_clk(sys_clk), .rom_pins(rom_pins), .rom_data(rom_data));
  function automatic logic [15:0] lo(input logic [28:0] a);
    return a[15:0] ^ 16'h5A3C;
  endfunction
  task automatic results();
    $display("checked %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(negedge sys_clk);
    {reg_sel, reg_wr, reg_addr, reg_wdata} = {2'b11, a, v};
    @(negedge sys_clk);
    {reg_sel, reg_wr} = 2'b00;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] v);
    @(negedge sys_clk);
    {reg_sel, reg_addr} = {1'b1, a};
    @(posedge sys_clk);
    v = reg_rdata;
    @(negedge sys_clk);
    reg_sel = 1'b0;
  endtask
  task automatic issue(input logic [28:0] a);
    @(negedge sys_clk);
    {fetch_valid, fetch_req.addr} = {1'b1, a};
    for (int i = 0; fetch_ready !== 1'b1; i++) begin
      if (i > 200) begin err_count++; results(); end
      @(negedge sys_clk);
    end
    @(negedge sys_clk);
    fetch_valid = 0;
    lat = 1;
  endtask
  task automatic wait_ack(output logic [31:0] v);
    while (fetch_ack !== 1'b1) begin
      if (lat > 200) begin err_count++; results(); end
      @(negedge sys_clk);
      lat++;
    end
    v = fetch_data;
  endtask
  task automatic t_reset();
    rd(16'h0080, r); chk("rom ctrl reset", 32'h0000_0040, r);
    rd(16'h0084, r); chk("clk ctrl reset", 32'h0000_0000, r);
    rd(16'h0088, r); chk("unmapped read", 32'h0000_0000, r);
    chk("boot address", 32'h0000_0000, boot_addr);
    $display("t_reset done");
  endtask
  task automatic t_boot16();
    for (int a = 0; a <= 4; a += 4) begin
      issue(a); wait_ack(d); chk("word from half words", {lo(2 * a + 4), lo(2 * a)}, d);
    end
    $display("t_boot16 done");
  endtask
  task automatic t_switch();
    issue(29'h0000_0008);
    wr(BRW_ROM_CTRL_OFS, 8'h00);
    wait_ack(d); chk("prefetched width kept", {lo(29'h14), lo(29'h10)}, d);
    rd(16'h0080, r); chk("rom ctrl written", 32'h0000_0000, {r, width16_active});
    issue(29'h0000_0008); wait_ack(d); chk("32-bit word", {~16'h0008, lo(29'h8)}, d);
    $display("t_switch done");
  endtask
  task automatic t_clock();
    @(negedge sys_clk); d[2:0] = {cpu_clk_en, mem_clk_en, io_clk_en};
    @(negedge sys_clk); chk("enables halved", 32'h0000_0007, d[2:0] ^ {cpu_clk_en, mem_clk_en, io_clk_en});
    wr(16'h0084, 8'h07); rd(16'h0084, r); chk("clk ctrl div1", 32'h0000_0007, r);
    @(negedge sys_clk); d[2:0] = {cpu_clk_en, mem_clk_en, io_clk_en};
    @(negedge sys_clk); chk("enables steady", 32'h0000_003F, {d[2:0], cpu_clk_en, mem_clk_en, io_clk_en});
    issue(29'h0000_000C); wait_ack(d); lat_n = lat;
    wr(BRW_ROM_CTRL_OFS, 8'h20);
    issue(29'h0000_000C); wait_ack(d); chk("half speed word", {~16'h000C, lo(29'hC)}, d);
    chk("half speed doubles", 32'h0000_0007, lat - lat_n);
    wr(BRW_ROM_CTRL_OFS, 8'h05);
    issue(29'h0000_0010); wait_ack(d); chk("fastest timing word", {~16'h0010, lo(29'h10)}, d);
    $display("t_clock done");
  endtask
  initial begin
    sys_clk = 0;
    forever #50 sys_clk = ~sys_clk;
  end
  initial begin
    {resetn, reg_sel, reg_wr, fetch_valid, reg_addr, reg_wdata, fetch_req} = '0;
    repeat (2) @(negedge sys_clk);
    resetn = 1;
    t_reset();
    t_boot16();
    t_switch();
    t_clock();
    results();
  end
endmodule
`default_nettype wire
